/* File: verilog/dpsh_host.sv */
// Host controller for one port of the shared dual-port semaphore RAM.
// Assumes the far port is driven by an independent master on its own.
`timescale 1ns/1ps
`default_nettype none
module dpsh_host #(
	parameter int MAX_TRIES = dpsh_pkg::TAKE_TRIES,
	parameter int RETRY_CYC = dpsh_pkg::GAP_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire dpsh_pkg::dpsh_op_e cmd_op,
	input wire logic [dpsh_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [dpsh_pkg::DATA_W-1:0] cmd_wdata,
	input wire logic guard_en,
	// Response
	output logic rsp_valid,
	output logic rsp_err,
	output logic rsp_granted,
	output logic [dpsh_pkg::DATA_W-1:0] rsp_rdata,
	output logic [dpsh_pkg::SEM_COUNT-1:0] owned,
	// RAM port pins
	output logic [dpsh_pkg::ADDR_W-1:0] port_addr,
	output logic port_ce_n,
	output logic port_sem_n,
	output logic port_rw_n,
	output logic port_oe_n,
	output logic [dpsh_pkg::DATA_W-1:0] port_dout,
	output logic port_dout_oe,
	input wire logic [dpsh_pkg::DATA_W-1:0] port_din
);
	import dpsh_pkg::*;

	dpsh_cyc_if cyc ();

	dpsh_state_e state_r;
	dpsh_op_e op_r;
	logic [ADDR_W-1:0] addr_r;
	logic [TRY_W-1:0] tries_r;
	logic [TRY_W-1:0] gap_r;
	logic start_r;
	logic is_wr_r;
	logic is_sem_r;
	logic [ADDR_W-1:0] cyc_addr_r;
	logic [DATA_W-1:0] cyc_wdata_r;
	logic take_ok;
	logic give_ok;
	logic [SEM_IDX_W-1:0] op_idx;

	assign cyc.start = start_r;
	assign cyc.is_wr = is_wr_r;
	assign cyc.is_sem = is_sem_r;
	assign cyc.addr = cyc_addr_r;
	assign cyc.wdata = cyc_wdata_r;
	assign op_idx = sem_idx(addr_r);

	// Take confirmed by readback, not by the request write; give by the release write
	assign take_ok = (state_r == ST_SRD) && cyc.done
		&& (op_r == OP_TAKE) && !cyc.rdata[0];
	assign give_ok = (state_r == ST_SWR) && cyc.done
		&& (op_r == OP_GIVE);

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			op_r <= OP_READ;
			addr_r <= ADDR_RST;
			tries_r <= '0;
			gap_r <= '0;
			start_r <= 1'b0;
			is_wr_r <= 1'b0;
			is_sem_r <= 1'b0;
			cyc_addr_r <= ADDR_RST;
			cyc_wdata_r <= DATA_RST;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_err <= 1'b0;
			rsp_granted <= 1'b0;
			rsp_rdata <= DATA_RST;
		end else begin
			start_r <= 1'b0;
			rsp_valid <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						op_r <= cmd_op;
						addr_r <= cmd_addr;
						tries_r <= '0;
						case (cmd_op)
							OP_READ, OP_WRITE: begin
								// Touch a guarded region only while owning its latch
								if (guard_en && !owned[region_of(cmd_addr)]) begin
									rsp_valid <= 1'b1;
									rsp_err <= 1'b1;
									rsp_granted <= 1'b0;
									rsp_rdata <= DATA_RST;
									cmd_ready <= 1'b1;
								end else begin
									start_r <= 1'b1;
									is_sem_r <= 1'b0;
									is_wr_r <= (cmd_op == OP_WRITE);
									cyc_addr_r <= cmd_addr;
									cyc_wdata_r <= cmd_wdata;
									state_r <= ST_MEM;
								end
							end
							OP_TAKE: begin
								if (owned[sem_idx(cmd_addr)]) begin
									rsp_valid <= 1'b1;
									rsp_err <= 1'b0;
									rsp_granted <= 1'b1;
									rsp_rdata <= DATA_RST;
									cmd_ready <= 1'b1;
								end else begin
									start_r <= 1'b1;
									is_sem_r <= 1'b1;
									is_wr_r <= 1'b1;
									cyc_addr_r <= ADDR_W'(sem_idx(cmd_addr));
									cyc_wdata_r <= SEM_REQUEST;
									state_r <= ST_SWR;
								end
							end
							OP_GIVE: begin
								// Only the owner may release
								if (!owned[sem_idx(cmd_addr)]) begin
									rsp_valid <= 1'b1;
									rsp_err <= 1'b1;
									rsp_granted <= 1'b0;
									rsp_rdata <= DATA_RST;
									cmd_ready <= 1'b1;
								end else begin
									start_r <= 1'b1;
									is_sem_r <= 1'b1;
									is_wr_r <= 1'b1;
									cyc_addr_r <= ADDR_W'(sem_idx(cmd_addr));
									cyc_wdata_r <= SEM_RELEASE;
									state_r <= ST_SWR;
								end
							end
							default: begin
								start_r <= 1'b1;
								is_sem_r <= 1'b1;
								is_wr_r <= 1'b0;
								cyc_addr_r <= ADDR_W'(sem_idx(cmd_addr));
								cyc_wdata_r <= DATA_RST;
								state_r <= ST_SRD;
							end
						endcase
					end
				end
				ST_MEM: begin
					if (cyc.done) begin
						rsp_valid <= 1'b1;
						rsp_err <= 1'b0;
						rsp_granted <= 1'b0;
						rsp_rdata <= op_r == OP_READ ? cyc.rdata : DATA_RST;
						cmd_ready <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
				ST_SWR: begin
					if (cyc.done) begin
						if (op_r == OP_TAKE) begin
							start_r <= 1'b1;
							is_wr_r <= 1'b0;
							state_r <= ST_SRD;
						end else begin
							rsp_valid <= 1'b1;
							rsp_err <= 1'b0;
							rsp_granted <= 1'b0;
							rsp_rdata <= DATA_RST;
							cmd_ready <= 1'b1;
							state_r <= ST_IDLE;
						end
					end
				end
				ST_SRD: begin
					if (cyc.done) begin
						if (op_r != OP_TAKE || take_ok) begin
							rsp_valid <= 1'b1;
							rsp_err <= 1'b0;
							rsp_granted <= !cyc.rdata[0];
							rsp_rdata <= cyc.rdata;
							cmd_ready <= 1'b1;
							state_r <= ST_IDLE;
						end else if (tries_r == TRY_W'(MAX_TRIES - 1)) begin
							// Withdraw so a late grant is not left stranded
							start_r <= 1'b1;
							is_wr_r <= 1'b1;
							cyc_wdata_r <= SEM_RELEASE;
							state_r <= ST_WDRAW;
						end else begin
							// Request stays pending in the latch; poll only
							gap_r <= TRY_W'(RETRY_CYC - 1);
							state_r <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					if (gap_r == '0) begin
						tries_r <= tries_r + 1'b1;
						start_r <= 1'b1;
						is_wr_r <= 1'b0;
						state_r <= ST_SRD;
					end else begin
						gap_r <= gap_r - 1'b1;
					end
				end
				default: begin
					if (cyc.done) begin
						rsp_valid <= 1'b1;
						rsp_err <= 1'b0;
						rsp_granted <= 1'b0;
						rsp_rdata <= DATA_RST;
						cmd_ready <= 1'b1;
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Ownership record; the latch itself settles any tie
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			owned <= OWN_RST;
		end else if (take_ok) begin
			owned[op_idx] <= 1'b1;
		end else if (give_ok) begin
			owned[op_idx] <= 1'b0;
		end
	end

	dpsh_cycle u_cycle (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.cyc(cyc.exec),
		.port_addr(port_addr),
		.port_ce_n(port_ce_n),
		.port_sem_n(port_sem_n),
		.port_rw_n(port_rw_n),
		.port_oe_n(port_oe_n),
		.port_dout(port_dout),
		.port_dout_oe(port_dout_oe),
		.port_din(port_din)
	);
endmodule
`default_nettype wire

/* File: include/dpsh_pkg.sv */
// Constants, types and decoders for the dual-port semaphore RAM host.
// Assumes one 25 MHz clock and a single port of the shared RAM.
`default_nettype none
package dpsh_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SEM_COUNT = 8;
	localparam int SEM_IDX_W = 3;
	localparam int REGION_LSB = ADDR_W - SEM_IDX_W;
	localparam int CNT_W = 4;
	localparam int TRY_W = 8;

	localparam int CLK_PERIOD_NS = 40;
	localparam int SETUP_NS = 40;
	localparam int STROBE_NS = 80;
	localparam int RETRY_GAP_NS = 400;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = (RETRY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TAKE_TRIES = 16;

	localparam logic [DATA_W-1:0] SEM_REQUEST = 8'h00;
	localparam logic [DATA_W-1:0] SEM_RELEASE = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [SEM_COUNT-1:0] OWN_RST = 8'h00;

	typedef enum logic [2:0] {
		OP_READ = 3'b000,
		OP_WRITE = 3'b001,
		OP_TAKE = 3'b010,
		OP_GIVE = 3'b011,
		OP_PEEK = 3'b100
	} dpsh_op_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_MEM = 3'b001,
		ST_SWR = 3'b010,
		ST_SRD = 3'b011,
		ST_GAP = 3'b100,
		ST_WDRAW = 3'b101
	} dpsh_state_e;

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SET = 2'b01,
		CY_ACT = 2'b10,
		CY_REC = 2'b11
	} dpsh_cyc_state_e;

	// Latch index from the low address bits
	function automatic logic [SEM_IDX_W-1:0] sem_idx(
		input logic [ADDR_W-1:0] a);
		sem_idx = a[SEM_IDX_W-1:0];
	endfunction

	// Memory region guarded by each latch
	function automatic logic [SEM_IDX_W-1:0] region_of(
		input logic [ADDR_W-1:0] a);
		region_of = a[ADDR_W-1:REGION_LSB];
	endfunction
endpackage
`default_nettype wire

/* File: include/dpsh_cyc_if.sv */
// Request and answer of one pin cycle between sequencer and cycle engine.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface dpsh_cyc_if;
	logic start;
	logic is_wr;
	logic is_sem;
	logic [dpsh_pkg::ADDR_W-1:0] addr;
	logic [dpsh_pkg::DATA_W-1:0] wdata;
	logic [dpsh_pkg::DATA_W-1:0] rdata;
	logic done;

	modport master (output start, is_wr, is_sem, addr, wdata,
		input rdata, done);
	modport exec (input start, is_wr, is_sem, addr, wdata,
		output rdata, done);
endinterface
`default_nettype wire

/* File: verilog/dpsh_cycle.sv */
// Pin cycle engine: one read or write on the RAM port per start pulse.
// Assumes the port inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dpsh_cycle (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Sequencer side
	dpsh_cyc_if.exec cyc,
	// RAM port pins
	output logic [dpsh_pkg::ADDR_W-1:0] port_addr,
	output logic port_ce_n,
	output logic port_sem_n,
	output logic port_rw_n,
	output logic port_oe_n,
	output logic [dpsh_pkg::DATA_W-1:0] port_dout,
	output logic port_dout_oe,
	input wire logic [dpsh_pkg::DATA_W-1:0] port_din
);
	import dpsh_pkg::*;

	dpsh_cyc_state_e state_r;
	logic [CNT_W-1:0] cnt_r;
	logic wr_r;
	logic done_r;
	logic [DATA_W-1:0] rdata_r;

	assign cyc.done = done_r;
	assign cyc.rdata = rdata_r;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= CY_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			done_r <= 1'b0;
			rdata_r <= DATA_RST;
			port_addr <= ADDR_RST;
			port_ce_n <= 1'b1;
			port_sem_n <= 1'b1;
			port_rw_n <= 1'b1;
			port_oe_n <= 1'b1;
			port_dout <= DATA_RST;
			port_dout_oe <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				CY_IDLE: begin
					if (cyc.start) begin
						port_addr <= cyc.addr;
						port_dout <= cyc.wdata;
						port_dout_oe <= cyc.is_wr;
						port_ce_n <= cyc.is_sem;
						port_sem_n <= !cyc.is_sem;
						port_oe_n <= cyc.is_wr;
						wr_r <= cyc.is_wr;
						cnt_r <= CNT_W'(SETUP_CYC - 1);
						state_r <= CY_SET;
					end
				end
				CY_SET: begin
					// Address settles before the write strobe opens
					if (cnt_r == '0) begin
						port_rw_n <= !wr_r;
						cnt_r <= CNT_W'(STROBE_CYC - 1);
						state_r <= CY_ACT;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				CY_ACT: begin
					if (cnt_r == '0) begin
						rdata_r <= port_din;
						port_rw_n <= 1'b1;
						port_ce_n <= 1'b1;
						port_sem_n <= 1'b1;
						port_oe_n <= 1'b1;
						state_r <= CY_REC;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					// Data held one cycle past the strobe for hold time
					port_dout_oe <= 1'b0;
					done_r <= 1'b1;
					state_r <= CY_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: sim/dpsh_ram_model.sv */
// Behavioural dual-port semaphore RAM, host pins on the left port.
// Assumes the right port is steered by the bench through r_want.
`timescale 1ns/1ps
`default_nettype none
module dpsh_ram_model (
	// Left port pins
	input wire logic sys_clk,
	input wire logic [11:0] port_addr,
	input wire logic port_ce_n,
	input wire logic port_sem_n,
	input wire logic port_rw_n,
	input wire logic port_oe_n,
	input wire logic [7:0] port_dout,
	input wire logic port_dout_oe,
	output logic [7:0] port_din,
	// Right port requests, one level per latch
	input wire logic [7:0] r_want
);
	logic [7:0] mem [4096];
	logic [7:0] l_own, r_own, l_req;
	logic [7:0] val, last, wd;
	logic [2:0] i;
	assign i = port_addr[2:0];
	assign val = !port_sem_n ? {7'h7F, !l_own[i]} : mem[port_addr];
	// Undriven bus shows the inverse of the last byte read, not a stale copy
	assign port_din = (!port_oe_n && !(port_ce_n && port_sem_n))
		? val : ~last;
	assign wd = port_dout_oe ? port_dout : ~last;
	initial begin
		l_own = 8'h00;
		r_own = 8'h00;
		l_req = 8'h00;
		last = 8'h00;
	end
	always @(posedge sys_clk) begin
		if (!port_oe_n)
			last <= port_din;
		if (!port_ce_n && !port_rw_n)
			mem[port_addr] <= wd;
		if (!port_sem_n && !port_rw_n)
			l_req[i] <= !wd[0];
	end
	// Left wins a tie; a pending request is granted on release
	always @(posedge sys_clk) begin
		for (int k = 0; k < 8; k++) begin
			l_own[k] <= l_req[k] && (l_own[k] || !r_own[k]);
			r_own[k] <= r_want[k]
				&& (r_own[k] || !(l_own[k] || l_req[k]));
		end
	end
endmodule
`default_nettype wire

/* File: sim/dpsh_host_chk.sv */
// Pin and response checks for the semaphore RAM host.
// Assumes it is bound into dpsh_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dpsh_host_chk (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Command and response
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire dpsh_pkg::dpsh_op_e cmd_op,
	input wire logic [dpsh_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic guard_en,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [dpsh_pkg::SEM_COUNT-1:0] owned,
	// RAM port pins
	input wire logic [dpsh_pkg::ADDR_W-1:0] port_addr,
	input wire logic port_ce_n,
	input wire logic port_sem_n,
	input wire logic port_rw_n,
	input wire logic port_oe_n,
	input wire logic [dpsh_pkg::DATA_W-1:0] port_dout,
	input wire logic port_dout_oe
);
	import dpsh_pkg::*;
	logic take;
	assign take = cmd_valid && cmd_ready;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_one_select: assert property (port_ce_n || port_sem_n)
		else $error("both selects low");
	a_sem_addr: assert property (
		!port_sem_n |-> port_addr[11:3] == 9'h000)
		else $error("latch address high bits set");
	a_sem_bit0: assert property (
		!port_sem_n && !port_rw_n |-> port_dout[7:1] == 7'h00)
		else $error("latch write uses upper bits");
	a_wr_drive: assert property (
		!port_rw_n |-> port_dout_oe && !(port_ce_n && port_sem_n))
		else $error("write without drive or select");
	a_rd_quiet: assert property (
		!port_oe_n |-> port_rw_n && !port_dout_oe)
		else $error("output enable during write");
	a_idle_pins: assert property (
		cmd_ready |-> port_ce_n && port_sem_n && port_rw_n)
		else $error("select active while idle");
	a_guard_refuse: assert property (
		take && guard_en && cmd_op inside {OP_READ, OP_WRITE}
		&& !owned[cmd_addr[11:9]]
		|=> port_ce_n throughout ##[0:1] (rsp_valid && rsp_err))
		else $error("unguarded access not refused");
	a_give_refuse: assert property (
		take && cmd_op == OP_GIVE && !owned[cmd_addr[2:0]]
		|=> port_sem_n throughout ##[0:1] (rsp_valid && rsp_err))
		else $error("give of free latch not refused");
	c_err: cover property (rsp_valid && rsp_err);
	c_sem_wr: cover property (!port_sem_n && !port_rw_n);
	c_take: cover property (take && cmd_op == OP_TAKE);
endmodule
bind dpsh_host dpsh_host_chk i_chk (.sys_clk, .rst_n, .cmd_valid, .cmd_ready,
	.cmd_op, .cmd_addr, .guard_en, .rsp_valid, .rsp_err, .owned, .port_addr,
	.port_ce_n, .port_sem_n, .port_rw_n, .port_oe_n, .port_dout,
	.port_dout_oe);
`default_nettype wire

/* File: sim/dpsh_host_tb_top.sv */
// Self-checking bench for the semaphore RAM host.
// Assumes dpsh_ram_model stands on the pins; right port via r_want.
`timescale 1ns/1ps
`default_nettype none
module dpsh_host_tb_top;
	import dpsh_pkg::*;
	logic sys_clk, rst_n, cmd_valid, cmd_ready, guard_en;
	dpsh_op_e cmd_op;
	logic [11:0] cmd_addr, port_addr;
	logic [7:0] cmd_wdata, rsp_rdata, owned, port_dout, port_din, r_want;
	logic rsp_valid, rsp_err, rsp_granted;
	logic port_ce_n, port_sem_n, port_rw_n, port_oe_n, port_dout_oe;
	int err_count, compares;
	// Short retry figures keep contention runs brief
	dpsh_host #(.MAX_TRIES(3), .RETRY_CYC(4)) i_dut (.sys_clk, .rst_n,
		.cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .guard_en,
		.rsp_valid, .rsp_err, .rsp_granted, .rsp_rdata, .owned, .port_addr,
		.port_ce_n, .port_sem_n, .port_rw_n, .port_oe_n, .port_dout,
		.port_dout_oe, .port_din);
	dpsh_ram_model i_ram (.sys_clk, .port_addr, .port_ce_n, .port_sem_n,
		.port_rw_n, .port_oe_n, .port_dout, .port_dout_oe, .port_din, .r_want);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic conclude;
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] g, input logic [11:0] e,
		input string m);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic cmd(input dpsh_op_e op, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 300);
		cmd_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 300) begin
			err_count++;
			conclude();
		end
	endtask
	task automatic t_mem;
		cmd(OP_WRITE, 12'hFFF, 8'hA5);
		chk(i_ram.mem[12'hFFF], 12'h0A5, "mem write");
		i_ram.mem[12'h000] = 8'h3C;
		cmd(OP_READ, 12'h000, 8'h00);
		chk(rsp_rdata, 12'h03C, "mem read");
	endtask
	task automatic t_sem;
		for (int k = 0; k < 8; k++) begin
			cmd(OP_TAKE, {9'h1F5, k[2:0]}, 8'h00);
			chk(rsp_granted, 1, "take");
			chk(i_ram.l_own, 12'h001 << k, "latch");
			cmd(OP_PEEK, {9'h000, k[2:0]}, 8'h00);
			chk(rsp_rdata, 12'h0FE, "peek own");
			chk(rsp_granted, 1, "peek granted");
			cmd(OP_GIVE, {9'h000, k[2:0]}, 8'h00);
			chk(owned, 12'h000, "give");
		end
		cmd(OP_GIVE, 12'h005, 8'h00);
		chk(rsp_err, 1, "give free");
		cmd(OP_PEEK, 12'h005, 8'h00);
		chk(rsp_rdata, 12'h0FF, "peek free");
	endtask
	task automatic t_contend;
		r_want <= 8'h08;
		repeat (3) @(posedge sys_clk);
		cmd(OP_TAKE, 12'h003, 8'h00);
		chk({rsp_granted, rsp_err}, 0, "held take");
		chk(owned, 12'h000, "not owned");
		fork
			cmd(OP_TAKE, 12'h003, 8'h00);
			begin
				repeat (8) @(posedge sys_clk);
				r_want <= 8'h00;
			end
		join
		chk(rsp_granted, 1, "pending grant");
		chk(owned, 12'h008, "owned after wait");
		cmd(OP_GIVE, 12'h003, 8'h00);
		// Right asks while our request is in flight
		fork
			cmd(OP_TAKE, 12'h004, 8'h00);
			begin
				repeat (4) @(posedge sys_clk);
				r_want <= 8'h10;
			end
		join
		chk(i_ram.l_own ^ i_ram.r_own, 12'h010, "one owner");
		chk(owned, i_ram.l_own, "owned mirror");
		cmd(OP_GIVE, 12'h004, 8'h00);
		r_want <= 8'h00;
	endtask
	task automatic t_guard;
		guard_en <= 1'b1;
		i_ram.mem[12'h400] = 8'h00;
		cmd(OP_WRITE, 12'h400, 8'h77);
		chk(rsp_err, 1, "guard miss");
		chk(i_ram.mem[12'h400], 12'h000, "guard mem");
		cmd(OP_TAKE, 12'h002, 8'h00);
		cmd(OP_TAKE, 12'h002, 8'h00);
		chk(rsp_granted, 1, "retake");
		cmd(OP_WRITE, 12'h400, 8'h77);
		chk(i_ram.mem[12'h400], 12'h077, "guard hit");
		cmd(OP_GIVE, 12'h002, 8'h00);
		guard_en <= 1'b0;
	endtask
	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_addr = 12'h000;
		cmd_wdata = 8'h00;
		guard_en = 1'b0;
		r_want = 8'h00;
		err_count = 0;
		compares = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk({port_ce_n, port_sem_n}, 3, "idle pins");
		t_mem();
		t_sem();
		t_contend();
		t_guard();
		conclude();
	end
endmodule
`default_nettype wire
